// *** hw/fess_top.sv ***
// host sequencer: drives erase, program and suspend flows into a nor flash
//
// Behaviour
// R01 - program suspend waits 15 us worst case
// R02 - program suspend may be written at any address
// R03 - program suspend: no reads of suspended sectors
// R04 - autoselect in program suspend; exit returns there
// R05 - program resume at any address
// R06 - chip erase: six writes ending with 10h
// R07 - no preprogram cycles from the host
// R08 - erase end, seen on ready, returns to read
// R09 - chip erase takes no commands; hardware reset ends it
// R10 - sector erase: six writes ending with 30h at sector
// R11 - acceptance window queues more sector-erase writes, any order
// R12 - added sectors within 50 us of the previous
// R13 - window writes that would abort are refused
// R14 - window timed from the last write's rising strobe edge
// R15 - running sector erase accepts only erase suspend
// R16 - erase suspend B0h only during sector erase or its window
// R17 - no erase suspend during chip erase or a program
// R18 - erase suspend while erasing waits 20 us
// R19 - erase suspend in the window suspends at once
// R20 - erase-suspended sectors read status; others read and program
// R21 - program in erase suspend ends back in erase suspend
// R22 - erase resume written inside an erase-suspended sector
// R23 - data polling bit of last read is reported in status
// R24 - ready/busy high means the operation finished
// R25 - host tracks read, window, erase, suspend, nested and autoselect
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module fess_top
  import fess_pkg::*;
#(
  parameter int WIN_CYC = WIN_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // flash pins
  output logic [AW-1:0] flash_addr,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [DW-1:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  input wire logic ready_busy_out_n
);
  typedef enum logic [1:0] {Q_IDLE, Q_BUS, Q_WAIT, Q_RST} fess_seq_t;

  fess_reg_if rif();
  fess_cyc_if cif();

  fess_seq_t q_r;
  fess_mode_t mode_r;
  fess_mode_t ret_r;
  fess_mode_t pend_r;
  logic [3:0] kind_r;
  logic [2:0] step_r;
  logic sent_r;
  logic req_r;
  logic err_r;
  logic held_r;
  logic dpoll_r;
  logic rb_meta_r;
  logic rb_s_r;
  logic [CW-1:0] wait_r;
  logic [CW-1:0] guard_r;
  logic [CW-1:0] win_cnt_r;
  logic [NSECT-1:0] mask_r;
  logic [SW-1:0] psect_r;
  logic [AW-1:0] ca_r;
  logic [DW-1:0] cd_r;
  logic [DW-1:0] rdata_r;
  fess_cyc_t cyc_r;
  logic ok;
  logic in_mask;
  logic busy_mode;

  fess_axil u_axil (
    .clk(clk),
    .rst(rst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .rif(rif.slv)
  );

  fess_pins u_pins (
    .clk(clk),
    .rst(rst),
    .cif(cif.pin),
    .flash_addr(flash_addr),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n),
    .flash_dq_i(flash_dq_i)
  );

  function automatic logic [SW-1:0] sect_of(logic [AW-1:0] a);
    return a[AW-1:SECT_LSB];
  endfunction

  function automatic logic [AW-1:0] sect_base(logic [AW-1:0] a);
    return {a[AW-1:SECT_LSB], {SECT_LSB{1'b0}}};
  endfunction

  function automatic logic [2:0] seq_last(logic [3:0] c);
    case (c)
      CMD_PROG: return 3'h3;
      CMD_CHIP, CMD_SECT: return 3'h5;
      CMD_AUTO_IN: return 3'h2;
      default: return 3'h0;
    endcase
  endfunction

  // one bus cycle of a command flow
  function automatic fess_cyc_t seq_step(logic [3:0] c, logic [2:0] i,
                                         logic [AW-1:0] a, logic [DW-1:0] d);
    fess_cyc_t s;
    logic multi;
    s.wr = (c != CMD_READ) && (c != CMD_AUTO_RD);
    s.a = a;
    s.d = d;
    multi = (c == CMD_PROG) || (c == CMD_CHIP) || (c == CMD_SECT) ||
            (c == CMD_AUTO_IN);
    case (c)
      CMD_SUSP: s.d = CODE_SUSP; // R02 R16
      CMD_RESUME: s.d = CODE_RESUME; // R05 R22
      CMD_AUTO_EX: s.d = CODE_RESET;
      CMD_ADD: begin
        s.a = sect_base(a); // R11
        s.d = CODE_SECT;
      end
      default: ;
    endcase
    if (multi) begin
      if (i == 3'h0 || (i == 3'h3 && c != CMD_PROG)) begin
        s.a = ADDR_UNL1; // R06 R10
        s.d = CODE_UNL1;
      end else if (i == 3'h1 || i == 3'h4) begin
        s.a = ADDR_UNL2;
        s.d = CODE_UNL2;
      end else if (i == 3'h2) begin
        s.a = ADDR_UNL1;
        s.d = (c == CMD_PROG) ? CODE_PROG :
              (c == CMD_AUTO_IN) ? CODE_AUTO : CODE_ERASE;
      end else if (c == CMD_CHIP) begin
        s.a = ADDR_UNL1; // R06 R07
        s.d = CODE_CHIP;
      end else if (c == CMD_SECT) begin
        s.a = sect_base(a); // R10
        s.d = CODE_SECT;
      end
    end
    return s;
  endfunction

  // ready/busy is an open-drain pin from the device
  always_ff @(posedge clk) begin
    if (rst) begin
      rb_meta_r <= 1'b0;
      rb_s_r <= 1'b0;
    end else begin
      rb_meta_r <= ready_busy_out_n;
      rb_s_r <= rb_meta_r;
    end
  end

  // refuse what the device would ignore or what would wreck a flow
  always_comb begin
    in_mask = mask_r[sect_of(rif.addr)];
    busy_mode = (mode_r == M_PROG) || (mode_r == M_CHIP) ||
                (mode_r == M_ERASE) || (mode_r == M_PESUS);
    ok = 1'b0;
    case (rif.cmd)
      CMD_HWRST: ok = 1'b1; // R09 R15
      CMD_PROG: ok = (mode_r == M_READ) ||
                     (mode_r == M_ESUSP && !in_mask); // R20
      CMD_READ: begin
        if (mode_r == M_READ || mode_r == M_ESUSP) ok = 1'b1; // R20
        else if (mode_r == M_PSUSP) ok = (sect_of(rif.addr) != psect_r) &&
                                          !(held_r && in_mask); // R03
      end
      CMD_CHIP, CMD_SECT: ok = (mode_r == M_READ);
      CMD_ADD: ok = (mode_r == M_WIN) &&
                    (int'(win_cnt_r) + WR_TOT < WIN_CYC); // R12 R13
      CMD_SUSP: ok = (mode_r == M_PROG) || (mode_r == M_PESUS) ||
                     (mode_r == M_WIN) || (mode_r == M_ERASE); // R16 R17
      CMD_RESUME: ok = (mode_r == M_PSUSP) ||
                       (mode_r == M_ESUSP && in_mask); // R05 R22
      CMD_AUTO_IN: ok = (mode_r == M_READ) || (mode_r == M_PSUSP) ||
                        (mode_r == M_ESUSP); // R04 R21
      CMD_AUTO_RD, CMD_AUTO_EX: ok = (mode_r == M_AUTO);
      default: ok = 1'b0;
    endcase
  end

  // status word seen by software
  always_comb begin
    rif.stat = 32'h00000000;
    rif.stat[ST_BUSY] = (q_r != Q_IDLE);
    rif.stat[ST_ERR] = err_r;
    rif.stat[ST_RB] = rb_s_r; // R24
    rif.stat[ST_WIN] = (mode_r == M_WIN); // R14
    rif.stat[ST_DPOLL] = dpoll_r; // R23
    rif.stat[ST_MODE +: 4] = mode_r;
  end

  assign rif.rdata = rdata_r;
  assign cif.req = req_r;
  assign cif.wr = cyc_r.wr;
  assign cif.addr = cyc_r.a;
  assign cif.data = cyc_r.d;

  // sequencer and host copy of device state
  always_ff @(posedge clk) begin
    if (rst) begin
      q_r <= Q_IDLE;
      mode_r <= M_READ;
      ret_r <= M_READ;
      pend_r <= M_READ;
      kind_r <= 4'h0;
      step_r <= 3'h0;
      sent_r <= 1'b0;
      req_r <= 1'b0;
      err_r <= 1'b0;
      held_r <= 1'b0;
      dpoll_r <= 1'b0;
      wait_r <= '0;
      guard_r <= '0;
      win_cnt_r <= '0;
      mask_r <= '0;
      psect_r <= '0;
      ca_r <= '0;
      cd_r <= '0;
      rdata_r <= '0;
      cyc_r <= '0;
      flash_reset_n <= 1'b1;
    end else begin
      req_r <= 1'b0;
      if (guard_r != '0) guard_r <= guard_r - CW'(1);
      if (mode_r == M_WIN) win_cnt_r <= win_cnt_r + CW'(1); // R14
      unique case (q_r)
        Q_IDLE: begin
          if (rif.cmd_vld) begin
            err_r <= ~ok;
            if (ok) begin
              kind_r <= rif.cmd;
              ca_r <= rif.addr;
              cd_r <= rif.wdata;
              step_r <= 3'h0;
              q_r <= Q_BUS;
              if (rif.cmd == CMD_HWRST) begin
                flash_reset_n <= 1'b0; // R09 R15
                wait_r <= RST_CNT;
                q_r <= Q_RST;
              end
            end
          end else if (mode_r == M_WIN && int'(win_cnt_r) >= WIN_CYC) begin
            mode_r <= M_ERASE; // R11 R14
            guard_r <= BUSY_CNT;
          end else if (busy_mode && guard_r == '0 && rb_s_r) begin
            // guard skips the interval before busy is valid on the pin
            if (mode_r == M_PESUS) begin
              mode_r <= M_ESUSP; // R21 R24
            end else begin
              mode_r <= M_READ; // R08
              mask_r <= '0;
            end
          end
        end
        Q_BUS: begin
          if (!sent_r) begin
            req_r <= 1'b1;
            sent_r <= 1'b1;
            cyc_r <= seq_step(kind_r, step_r, ca_r, cd_r);
          end else if (cif.done) begin
            sent_r <= 1'b0;
            if (step_r != seq_last(kind_r)) begin
              step_r <= step_r + 3'h1;
            end else begin
              q_r <= Q_IDLE;
              case (kind_r)
                CMD_READ, CMD_AUTO_RD: begin
                  rdata_r <= cif.rdata; // R20
                  dpoll_r <= cif.rdata[7]; // R23
                end
                CMD_PROG: begin
                  mode_r <= (mode_r == M_ESUSP) ? M_PESUS : M_PROG; // R21
                  psect_r <= sect_of(ca_r);
                  guard_r <= BUSY_CNT;
                end
                CMD_CHIP: begin
                  mode_r <= M_CHIP; // R09
                  mask_r <= '1;
                  guard_r <= BUSY_CNT;
                end
                CMD_SECT: begin
                  mode_r <= M_WIN; // R11 R14
                  mask_r <= '0;
                  mask_r[sect_of(ca_r)] <= 1'b1;
                  win_cnt_r <= '0;
                end
                CMD_ADD: begin
                  mask_r[sect_of(ca_r)] <= 1'b1; // R11
                  win_cnt_r <= '0; // R14
                end
                CMD_SUSP: begin
                  if (mode_r == M_WIN) begin
                    mode_r <= M_ESUSP; // R19
                  end else begin
                    q_r <= Q_WAIT;
                    pend_r <= (mode_r == M_ERASE) ? M_ESUSP : M_PSUSP;
                    held_r <= (mode_r == M_PESUS); // R03
                    wait_r <= (mode_r == M_ERASE) ? ESUSP_CNT : PSUSP_CNT;
                  end // R01 R18
                end
                CMD_RESUME: begin
                  if (mode_r == M_ESUSP) mode_r <= M_ERASE; // R22
                  else mode_r <= held_r ? M_PESUS : M_PROG; // R05
                  guard_r <= BUSY_CNT;
                end
                CMD_AUTO_IN: begin
                  ret_r <= mode_r; // R04 R25
                  mode_r <= M_AUTO;
                end
                CMD_AUTO_EX: mode_r <= ret_r; // R04 R25
                default: ;
              endcase
            end
          end
        end
        Q_WAIT: begin
          // worst-case suspend latency, no polling needed
          if (wait_r == '0) begin
            mode_r <= pend_r;
            q_r <= Q_IDLE;
          end else begin
            wait_r <= wait_r - CW'(1);
          end
        end
        Q_RST: begin
          if (wait_r == '0) begin
            flash_reset_n <= 1'b1;
            mode_r <= M_READ; // R09 R15
            mask_r <= '0;
            held_r <= 1'b0;
            guard_r <= BUSY_CNT;
            q_r <= Q_IDLE;
          end else begin
            wait_r <= wait_r - CW'(1);
          end
        end
      endcase
    end
  end
endmodule

// *** hw/fess_pkg.sv ***
// package: constants and types of the flash erase/suspend host sequencer
package fess_pkg;
  localparam int CLK_MHZ = 200;
  // pin timing in ns, device latencies and acceptance window in us
  localparam int T_WE_NS = 35;
  localparam int T_WH_NS = 20;
  localparam int T_ACC_NS = 90;
  localparam int T_BUSY_NS = 90;
  localparam int T_RST_NS = 500;
  localparam int T_PSUSP_US = 15;
  localparam int T_ESUSP_US = 20;
  localparam int T_WIN_US = 50;
  localparam int SYNC_CYC = 2;

  // least times round up to whole cycles
  function automatic int ns_up(int ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction

  localparam int CW = 16;
  localparam logic [7:0] WE_CNT = 8'(ns_up(T_WE_NS));
  localparam logic [7:0] WH_CNT = 8'(ns_up(T_WH_NS));
  localparam logic [7:0] ACC_CNT = 8'(ns_up(T_ACC_NS) + SYNC_CYC);
  localparam logic [CW-1:0] BUSY_CNT = CW'(ns_up(T_BUSY_NS) + SYNC_CYC);
  localparam logic [CW-1:0] RST_CNT = CW'(ns_up(T_RST_NS));
  localparam logic [CW-1:0] PSUSP_CNT = CW'(T_PSUSP_US * CLK_MHZ);
  localparam logic [CW-1:0] ESUSP_CNT = CW'(T_ESUSP_US * CLK_MHZ);
  localparam int WIN_CYC_DEF = T_WIN_US * CLK_MHZ;
  // one pin write cycle, margin inside the window
  localparam int WR_TOT = 3 + ns_up(T_WE_NS) + ns_up(T_WH_NS);

  // flash bus geometry
  localparam int AW = 22;
  localparam int DW = 16;
  localparam int SECT_LSB = 15;
  localparam int SW = 7;
  localparam int NSECT = 128;
  localparam logic [AW-1:0] ADDR_UNL1 = 22'h000555;
  localparam logic [AW-1:0] ADDR_UNL2 = 22'h0002AA;
  localparam logic [DW-1:0] CODE_UNL1 = 16'h00AA;
  localparam logic [DW-1:0] CODE_UNL2 = 16'h0055;
  localparam logic [DW-1:0] CODE_ERASE = 16'h0080;
  localparam logic [DW-1:0] CODE_CHIP = 16'h0010;
  localparam logic [DW-1:0] CODE_SECT = 16'h0030;
  localparam logic [DW-1:0] CODE_RESUME = 16'h0030;
  localparam logic [DW-1:0] CODE_PROG = 16'h00A0;
  localparam logic [DW-1:0] CODE_AUTO = 16'h0090;
  localparam logic [DW-1:0] CODE_SUSP = 16'h00B0;
  localparam logic [DW-1:0] CODE_RESET = 16'h00F0;

  // register map of the host block
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int ST_BUSY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_RB = 2;
  localparam int ST_WIN = 3;
  localparam int ST_DPOLL = 4;
  localparam int ST_MODE = 8;

  // software commands written to the control register
  localparam logic [3:0] CMD_PROG = 4'h1;
  localparam logic [3:0] CMD_READ = 4'h2;
  localparam logic [3:0] CMD_CHIP = 4'h3;
  localparam logic [3:0] CMD_SECT = 4'h4;
  localparam logic [3:0] CMD_ADD = 4'h5;
  localparam logic [3:0] CMD_SUSP = 4'h6;
  localparam logic [3:0] CMD_RESUME = 4'h7;
  localparam logic [3:0] CMD_AUTO_IN = 4'h8;
  localparam logic [3:0] CMD_AUTO_RD = 4'h9;
  localparam logic [3:0] CMD_AUTO_EX = 4'hA;
  localparam logic [3:0] CMD_HWRST = 4'hB;

  typedef enum logic [3:0] {
    M_READ, M_PROG, M_CHIP, M_WIN, M_ERASE, M_ESUSP, M_PESUS, M_PSUSP,
    M_AUTO
  } fess_mode_t;

  typedef struct packed {
    logic wr;
    logic [AW-1:0] a;
    logic [DW-1:0] d;
  } fess_cyc_t;
endpackage

// *** hw/fess_if.sv ***
// interfaces: core to register slave and pin engine
`timescale 1ns/1ps
interface fess_reg_if;
  import fess_pkg::*;
  logic cmd_vld;
  logic [3:0] cmd;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [31:0] stat;
  logic [DW-1:0] rdata;
  modport slv (output cmd_vld, cmd, addr, wdata, input stat, rdata);
  modport core (input cmd_vld, cmd, addr, wdata, output stat, rdata);
endinterface

interface fess_cyc_if;
  import fess_pkg::*;
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [DW-1:0] data;
  logic done;
  logic [DW-1:0] rdata;
  modport drv (output req, wr, addr, data, input done, rdata);
  modport pin (input req, wr, addr, data, output done, rdata);
endinterface

// *** hw/fess_pins.sv ***
// pin engine: one asynchronous flash write or read cycle per request
`timescale 1ns/1ps
module fess_pins
  import fess_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // cycle requests
  fess_cyc_if.pin cif,
  // flash pins
  output logic [AW-1:0] flash_addr,
  output logic [DW-1:0] flash_dq_o,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  input wire logic [DW-1:0] flash_dq_i
);
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_PULSE, P_HOLD} fess_pin_t;
  fess_pin_t p_r;
  logic [7:0] cnt_r;
  logic wr_r;
  logic [DW-1:0] dq_meta_r;
  logic [DW-1:0] dq_s_r;

  // data pins are asynchronous
  always_ff @(posedge clk) begin
    dq_meta_r <= flash_dq_i;
    dq_s_r <= dq_meta_r;
  end

  // address settles a cycle before the strobe, data held past its rise
  always_ff @(posedge clk) begin
    if (rst) begin
      p_r <= P_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      flash_addr <= '0;
      flash_dq_o <= '0;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      cif.done <= 1'b0;
      cif.rdata <= '0;
    end else begin
      cif.done <= 1'b0;
      unique case (p_r)
        P_IDLE: begin
          if (cif.req) begin
            flash_addr <= cif.addr;
            flash_dq_o <= cif.data;
            flash_dq_oe <= cif.wr;
            wr_r <= cif.wr;
            flash_ce_n <= 1'b0;
            p_r <= P_SETUP;
          end
        end
        P_SETUP: begin
          flash_we_n <= ~wr_r;
          flash_oe_n <= wr_r;
          cnt_r <= wr_r ? WE_CNT : ACC_CNT;
          p_r <= P_PULSE;
        end
        P_PULSE: begin
          if (cnt_r == 8'h00) begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!wr_r) cif.rdata <= dq_s_r; // access time plus sync covered
            cnt_r <= WH_CNT;
            p_r <= P_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        P_HOLD: begin
          if (cnt_r == 8'h00) begin
            flash_ce_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            cif.done <= 1'b1;
            p_r <= P_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
      endcase
    end
  end
endmodule

// *** hw/fess_axil.sv ***
// axi4-lite slave holding the command, address and data registers
`timescale 1ns/1ps
module fess_axil
  import fess_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // core side
  fess_reg_if.slv rif
);
  logic [7:0] aw_r;
  logic [31:0] wd_r;
  logic [3:0] ws_r;

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  // aw and w in either order, answer once both held
  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_r <= 8'h00;
      wd_r <= 32'h00000000;
      ws_r <= 4'h0;
      rif.cmd_vld <= 1'b0;
      rif.cmd <= 4'h0;
      rif.addr <= '0;
      rif.wdata <= '0;
    end else begin
      rif.cmd_vld <= 1'b0;
      if (awvalid && awready) begin
        aw_r <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wd_r <= wdata;
        ws_r <= wstrb;
        wready <= 1'b0;
      end
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        bresp <= RESP_OKAY;
        unique case (aw_r)
          REG_CTRL: begin
            rif.cmd_vld <= ws_r[0];
            rif.cmd <= wd_r[3:0];
          end
          REG_ADDR: rif.addr <= AW'(merge(32'(rif.addr), wd_r, ws_r));
          REG_WDATA: rif.wdata <= DW'(merge(32'(rif.wdata), wd_r, ws_r));
          REG_STATUS, REG_RDATA: ;
          default: bresp <= RESP_SLVERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read channel, unmapped offsets get slverr
  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      rdata <= 32'h00000000;
      unique case (araddr)
        REG_CTRL: ;
        REG_ADDR: rdata <= 32'(rif.addr);
        REG_WDATA: rdata <= 32'(rif.wdata);
        REG_STATUS: rdata <= rif.stat;
        REG_RDATA: rdata <= 32'(rif.rdata);
        default: rresp <= RESP_SLVERR;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// *** bench/fess_properties.sv ***
// checker: strobe, reset and bus timing
`timescale 1ns/1ps
module fess_properties (
  // watched ports
  input wire logic clk, rst, bvalid, bready, awready, rvalid, rready,
  input wire logic flash_we_n, flash_ce_n, flash_oe_n, flash_dq_oe,
  input wire logic flash_reset_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // short pulses may be missed
  sequence s_we_low; !flash_we_n [*7]; endsequence
  sequence s_rst_low; !flash_reset_n [*8]; endsequence
  a_we_in_ce: assert property (!flash_we_n |-> !flash_ce_n)
    else $error("strobe outside select");
  a_we_drive: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("strobe without data");
  a_read_free: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("read while driving");
  a_we_width: assert property ($fell(flash_we_n) |=> s_we_low)
    else $error("strobe too short");
  a_rst_width: assert property ($fell(flash_reset_n) |=> s_rst_low)
    else $error("reset pulse short");
  a_b_hold: assert property (bvalid && !bready |=> bvalid)
    else $error("bvalid dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid)
    else $error("rvalid dropped");
  a_aw_block: assert property (bvalid |-> !awready)
    else $error("awready during response");
endmodule
bind fess_top fess_properties u_fess_properties (.*);

// *** bench/fess_flash.sv ***
// flash model: commands, busy time, status
`timescale 1ns/1ps
module fess_flash #(
  parameter int SLOW = 3000
) (
  // model pace and flash pins
  input wire logic clk, flash_reset_n, flash_ce_n, flash_we_n, flash_oe_n,
  input wire logic [21:0] flash_addr,
  input wire logic [15:0] flash_dq_i,
  output logic [15:0] q,
  output logic ready_busy_out_n,
  output int nw
);
  logic [15:0] h1, h2, h3, d, pat = 16'h5A5A;
  logic [2:0] m = 3'h0; // 0 read 1 prog 2 chip 3 erase 4/5 suspended
  logic we_q = 1'h1;
  int n;
  assign d = flash_dq_i;
  // writes taken at the rising strobe edge
  always @(posedge clk) begin
    we_q <= flash_we_n;
    pat <= ~pat;
    if (n > 0) n <= n - 1;
    if (n == 1 && m < 4) m <= 3'h0;
    if (!flash_reset_n) begin
      m <= 3'h0;
      n <= 0;
    end else if (flash_we_n && !we_q && !flash_ce_n) begin
      nw <= nw + 1;
      {h3, h2, h1} <= {h2, h1, d};
      if (d == 16'hB0 && m == 3) m <= 3'h4;
      else if (d == 16'hB0 && m == 1) m <= 3'h5;
      else if (d == 16'h30 && m > 3) m <= m == 4 ? 3'h3 : 3'h1;
      else if (m == 0 && d == 16'h10 && h3 == 16'h80) m <= 3'h2;
      else if (m == 0 && d == 16'h30 && h3 == 16'h80) m <= 3'h3;
      else if (m == 0 && h1 == 16'hA0) m <= 3'h1;
      if (m != 2 && (d == 16'h30 || d == 16'h10 || h1 == 16'hA0)) n <= SLOW;
    end
  end
  // released bus toggles
  assign ready_busy_out_n = !(m inside {3'h1, 3'h2, 3'h3});
  assign q = flash_oe_n ? pat : m inside {3'h2, 3'h3, 3'h4} ?
    {8'h00, m == 4, 7'h00} : flash_addr[15:0] ^ 16'hA5C3;
endmodule

// *** bench/fess_top_bench.sv ***
// bench: erase, program and suspend flows
`timescale 1ns/1ps
module fess_top_bench;
  import fess_pkg::*;
  logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_reset_n;
  logic ready_busy_out_n;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, s;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, br, rr;
  logic [AW-1:0] flash_addr;
  logic [DW-1:0] flash_dq_o, flash_dq_i, q;
  int miscompares = 0, checked = 0, cyc = 0, nw, k, seed = 32'hDF7FB5FA;
  // host drives dq while enabled
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : q;
  always #2.5 clk = ~clk;
  fess_top #(.WIN_CYC(600)) u_fess_top (.*);
  fess_flash u_fess_flash (.*);
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] v, e);
    checked++;
    if (v !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, v);
    end
  endtask
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    awaddr <= a;
    wdata <= dt;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    br = bresp;
    bready <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    s = rdata;
    rr = rresp;
    rready <= 0;
    @(posedge clk);
  endtask
  // launch, then poll busy
  task automatic cmd(input logic [3:0] c, input logic [31:0] a);
    wr(REG_ADDR, a);
    wr(REG_CTRL, {28'h0, c});
    repeat (2) @(posedge clk);
    do rd(REG_STATUS); while (s[ST_BUSY] !== 1'h0);
  endtask
  task automatic wm(input logic [3:0] md);
    do rd(REG_STATUS); while (s[11:8] !== md);
  endtask
  function automatic logic [31:0] ea(input logic [31:0] x);
    return x & 32'h003FFFFF;
  endfunction
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    k = $random(seed);
    wr(REG_ADDR, k);
    rd(REG_ADDR);
    chk("addr", s, ea(k));
    wr(8'h40, k);
    chk("bresp", br, RESP_SLVERR);
    rd(8'h40);
    chk("rresp", rr, RESP_SLVERR);
    k = nw;
    cmd(CMD_CHIP, 0);
    chk("writes", nw - k, 6);
    cmd(CMD_SUSP, 0);
    chk("err", s[ST_ERR], 1);
    wm(M_READ);
    chk("ready", s[ST_RB], 1);
    cmd(CMD_CHIP, 0);
    cmd(CMD_HWRST, 0);
    chk("mode", s[11:8], M_READ);
    k = $random(seed) & 32'h003F8000;
    cmd(CMD_SECT, k);
    chk("window", s[ST_WIN], 1);
    cmd(CMD_PROG, k);
    chk("err", s[ST_ERR], 1);
    cmd(CMD_ADD, k ^ 32'h8000);
    chk("mode", s[11:8], M_WIN);
    cmd(CMD_SUSP, $random(seed));
    chk("mode", s[11:8], M_ESUSP);
    cmd(CMD_READ, k);
    chk("dpoll", s[ST_DPOLL], 1);
    rd(REG_RDATA);
    chk("rdata", s, 32'h80);
    cmd(CMD_RESUME, k);
    chk("mode", s[11:8], M_ERASE);
    cmd(CMD_SUSP, 0);
    chk("mode", s[11:8], M_ESUSP);
    cmd(CMD_RESUME, k);
    wm(M_READ);
    wr(REG_WDATA, $random(seed));
    cmd(CMD_PROG, $random(seed));
    cmd(CMD_SUSP, $random(seed));
    chk("mode", s[11:8], M_PSUSP);
    cmd(CMD_RESUME, $random(seed));
    chk("mode", s[11:8], M_PROG);
    wm(M_READ);
    chk("ready", s[ST_RB], 1);
    end_sim;
  end
endmodule
